// [fan_pwm_override_spinup.sv]
// first fan output: override, polarity, hot lock and spin-up kick
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_override_spinup
    import fan_pwm_pkg::*;
#(
    parameter int MS_TICK = MS_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // device-wide configuration lock
    input wire logic cfg_lock,
    // other bound sources
    input wire logic [3:0] auto_duty_code,
    input wire logic cpu_hot_event,
    // fan drive
    output logic fan_output_one,
    output logic kick_active
);
    logic override_enable;
    logic polarity_flip;
    logic hot_lock_enable;
    logic hot_lock_flag;
    logic [3:0] manual_duty_code;
    logic [3:0] kick_duty_code;
    logic [3:0] kick_duration_code;
    logic [3:0] base_duty;
    logic [3:0] applied_duty;
    logic [3:0] frame_count;
    logic base_was_zero;
    logic kick_start;
    logic timer_busy;
    logic wr_ctl;
    logic wr_spin;

    assign wr_ctl = reg_wr && reg_addr == ADDR_OVERRIDE_LOCK;
    assign wr_spin = reg_wr && reg_addr == ADDR_SPINUP_SETUP;

    ////////////////////////////////////////////////////////////////////////
    // configuration fields; the write lock freezes them but not the flag
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            override_enable <= OVERRIDE_LOCK_RESET[BIT_OVERRIDE];
            polarity_flip <= OVERRIDE_LOCK_RESET[BIT_FLIP];
            hot_lock_enable <= OVERRIDE_LOCK_RESET[BIT_LOCK_EN];
            manual_duty_code <= OVERRIDE_LOCK_RESET[MANUAL_LSB +: 4];
        end else if (wr_ctl && !cfg_lock) begin
            override_enable <= reg_wdata[BIT_OVERRIDE];
            polarity_flip <= reg_wdata[BIT_FLIP];
            hot_lock_enable <= reg_wdata[BIT_LOCK_EN];
            manual_duty_code <= reg_wdata[MANUAL_LSB +: 4];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            kick_duty_code <= SPINUP_SETUP_RESET[KICK_DUTY_LSB +: 4];
            kick_duration_code <= {SPINUP_SETUP_RESET[DUR_MSB_BIT],
                SPINUP_SETUP_RESET[DUR_LOW_LSB +: 3]};
        end else if (wr_spin && !cfg_lock) begin
            kick_duty_code <= reg_wdata[KICK_DUTY_LSB +: 4];
            kick_duration_code <= {reg_wdata[DUR_MSB_BIT],
                reg_wdata[DUR_LOW_LSB +: 3]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hot lock: a new event in the clearing cycle keeps the flag set
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hot_lock_flag <= OVERRIDE_LOCK_RESET[BIT_LOCK_FLAG];
        end else if (hot_lock_enable && cpu_hot_event) begin
            hot_lock_flag <= 1'b1;
        end else if (wr_ctl && !reg_wdata[BIT_LOCK_FLAG]) begin
            hot_lock_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration: largest request wins, kick on top, lock forces full over both
    always_comb begin
        base_duty = auto_duty_code;
        if (override_enable && manual_duty_code > auto_duty_code) begin
            base_duty = manual_duty_code;
        end
        if (hot_lock_flag) begin
            base_duty = DUTY_FULL;
        end
    end

    // a zero kick duty or zero span never starts the timer
    assign kick_start = base_was_zero && base_duty != DUTY_ZERO
        && kick_duty_code != DUTY_ZERO
        && kick_duration_code != DUTY_ZERO;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            base_was_zero <= 1'b1;
        end else begin
            base_was_zero <= (base_duty == DUTY_ZERO);
        end
    end

    fan_spinup_timer #(
        .MS_TICK(MS_TICK)
    ) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .start(kick_start),
        .dur_code(kick_duration_code),
        .busy(timer_busy)
    );

    // kick ends with the timer or when the kick duty is rewritten to zero, and is held off while the hot lock flag is set
    assign kick_active = timer_busy && kick_duty_code != DUTY_ZERO
        && !hot_lock_flag;
    assign applied_duty = kick_active ? kick_duty_code : base_duty;

    ////////////////////////////////////////////////////////////////////////
    // pwm frame of 15 slots; frequency selection lives elsewhere
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            frame_count <= '0;
        end else if (frame_count == FRAME_LAST) begin
            frame_count <= '0;
        end else begin
            frame_count <= frame_count + 4'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fan_output_one <= 1'b0;
        end else begin
            fan_output_one <= (frame_count < applied_duty)
                ^ polarity_flip;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is registered; the duty field shows the applied duty, or zero during a kick
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_OVERRIDE_LOCK) begin
                reg_rdata <= {kick_active ? DUTY_ZERO : applied_duty,
                    hot_lock_flag, hot_lock_enable, polarity_flip,
                    override_enable};
            end else if (reg_addr == ADDR_SPINUP_SETUP) begin
                reg_rdata <= {kick_duration_code[2:0],
                    kick_duration_code[3], kick_duty_code};
            end else begin
                reg_rdata <= UNMAPPED_READ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_override_duty: assert property (
        @(posedge mclk) disable iff (!nrst)
        override_enable && !hot_lock_flag && !kick_active
        && manual_duty_code >= auto_duty_code
        |-> applied_duty == manual_duty_code)
        else $error("override duty not applied");
    a_max_source: assert property (
        @(posedge mclk) disable iff (!nrst)
        !kick_active |-> applied_duty >= auto_duty_code)
        else $error("applied duty below automatic request");
    a_full_high: assert property (
        @(posedge mclk) disable iff (!nrst)
        applied_duty == DUTY_FULL && !polarity_flip |=> fan_output_one)
        else $error("full duty not continuously high");
    a_full_low: assert property (
        @(posedge mclk) disable iff (!nrst)
        applied_duty == DUTY_FULL && polarity_flip |=> !fan_output_one)
        else $error("inverted full duty not continuously low");
    a_lock_sets: assert property (
        @(posedge mclk) disable iff (!nrst)
        hot_lock_enable && cpu_hot_event |=> hot_lock_flag)
        else $error("hot event did not set lock flag");
    a_lock_cause: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(hot_lock_flag) |-> $past(hot_lock_enable && cpu_hot_event))
        else $error("lock flag set without enabled hot event");
    a_lock_holds: assert property (
        @(posedge mclk) disable iff (!nrst)
        hot_lock_flag |-> applied_duty == DUTY_FULL)
        else $error("lock flag set but duty not full");
    a_lock_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        $fell(hot_lock_flag) |-> $past(wr_ctl)
        && !$past(reg_wdata[BIT_LOCK_FLAG]))
        else $error("lock flag cleared without a zero write");
    a_clear_unlocked: assert property (
        @(posedge mclk) disable iff (!nrst)
        hot_lock_flag && wr_ctl && !reg_wdata[BIT_LOCK_FLAG] && cfg_lock
        && !(hot_lock_enable && cpu_hot_event) |=> !hot_lock_flag)
        else $error("config lock blocked flag clear");
    a_kick_read: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd && reg_addr == ADDR_OVERRIDE_LOCK && kick_active
        |=> reg_rdata[7:4] == DUTY_ZERO)
        else $error("duty field not zero during kick");
    a_kick_start: assert property (
        @(posedge mclk) disable iff (!nrst)
        kick_start && !hot_lock_flag
        && !(hot_lock_enable && cpu_hot_event)
        && !(wr_spin && reg_wdata[3:0] == DUTY_ZERO)
        |=> kick_active ##0 applied_duty == kick_duty_code)
        else $error("zero to nonzero duty did not start kick");
    a_kick_off: assert property (
        @(posedge mclk) disable iff (!nrst)
        kick_duty_code == DUTY_ZERO |-> !kick_active)
        else $error("kick active with zero kick duty");
endmodule // fan_pwm_override_spinup
`default_nettype wire

// [fan_pwm_pkg.sv]
// constants, register map and spin-up timing for the first fan output
// Behaviour
// - override set: output uses manual duty code when it exceeds automatic request
// - flip clear: full duty holds output high; flip set: holds it low
// - bound cpu hot event sets the hot lock flag only while lock enabled
// - while hot lock flag set, output stays at full duty
// - hot lock flag clears only by writing zero; then normal control resumes
// - configuration write lock never blocks writes to the hot lock flag
// - manual duty code is bits 7:4, sixteen duty values under override
// - manual duty code reads zero while a spin-up kick runs
// - kick duty code is bits 3:0; zero disables spin-up
// - duty going zero to nonzero starts a kick of programmed duration
// - duration code msb is bit 4, low three bits are bits 7:5
// - duration 0 off; 100,250,400,700 ms,1,2,4 s; then 6 to 20 s
// - several sources active: the largest requested duty is applied; during a kick the code applies the kick duty even when it is smaller
package fan_pwm_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    // cycles of mclk in one millisecond tick
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

    localparam logic [7:0] ADDR_OVERRIDE_LOCK = 8'hc9;
    localparam logic [7:0] ADDR_SPINUP_SETUP = 8'hca;
    localparam logic [7:0] OVERRIDE_LOCK_RESET = 8'h00;
    localparam logic [7:0] SPINUP_SETUP_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // override and lock register fields
    localparam int BIT_OVERRIDE = 0;
    localparam int BIT_FLIP = 1;
    localparam int BIT_LOCK_EN = 2;
    localparam int BIT_LOCK_FLAG = 3;
    localparam int MANUAL_LSB = 4;
    // spin-up setup register fields
    localparam int KICK_DUTY_LSB = 0;
    localparam int DUR_MSB_BIT = 4;
    localparam int DUR_LOW_LSB = 5;

    localparam logic [3:0] DUTY_ZERO = 4'h0;
    localparam logic [3:0] DUTY_FULL = 4'hf;
    // pwm frame: codes 0..15 map onto 15 slots, so 15 means always on
    localparam logic [3:0] FRAME_LAST = 4'he;

    // kick durations in milliseconds, index is the 4-bit duration code
    localparam logic [14:0] KICK_MS [16] = '{
        15'h0000, 15'h0064, 15'h00fa, 15'h0190,
        15'h02bc, 15'h03e8, 15'h07d0, 15'h0fa0,
        15'h1770, 15'h1f40, 15'h2710, 15'h2ee0,
        15'h36b0, 15'h3e80, 15'h4650, 15'h4e20
    };
endpackage

// [fan_spinup_timer.sv]
// millisecond timer that holds the spin-up kick for its programmed span
`timescale 1ns/1ps
`default_nettype none
module fan_spinup_timer
    import fan_pwm_pkg::*;
#(
    parameter int MS_TICK = MS_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic [3:0] dur_code,
    // status
    output logic busy
);
    logic [15:0] sub_count;
    logic [14:0] ms_left;

    ////////////////////////////////////////////////////////////////////////
    // a restart reloads both counters, so back-to-back starts extend
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sub_count <= '0;
            ms_left <= '0;
        end else if (start) begin
            sub_count <= 16'(MS_TICK - 1);
            ms_left <= KICK_MS[dur_code];
        end else if (ms_left != '0) begin
            if (sub_count == '0) begin
                sub_count <= 16'(MS_TICK - 1);
                ms_left <= ms_left - 15'd1;
            end else begin
                sub_count <= sub_count - 16'd1;
            end
        end
    end

    assign busy = (ms_left != '0);

    a_tick_reload: assert property (
        @(posedge mclk) disable iff (!nrst)
        busy && sub_count == '0 |=> sub_count == 16'(MS_TICK - 1))
        else $error("millisecond tick did not reload");
    a_start_load: assert property (
        @(posedge mclk) disable iff (!nrst)
        start |=> ms_left == KICK_MS[$past(dur_code)])
        else $error("kick span not loaded from duration code");
endmodule // fan_spinup_timer
`default_nettype wire

// [fan_drive_model.sv]
// behavioural fan driver stage that reports the high slots of one frame
`timescale 1ns/1ps
`default_nettype none
module fan_drive_model #(
    parameter int FRAME = 15
) (
    // clock
    input wire logic mclk,
    // pwm line from the block
    input wire logic pwm_in,
    // measured drive
    output logic [3:0] high_count
);
    logic [FRAME-1:0] hist = '0;

    always @(posedge mclk) begin
        hist <= {hist[FRAME-2:0], pwm_in};
    end

    // any run of FRAME slots holds one whole frame, so no alignment needed
    always_comb begin
        high_count = 4'h0;
        for (int i = 0; i < FRAME; i++) begin
            high_count = high_count + 4'(hist[i]);
        end
    end
endmodule // fan_drive_model
`default_nettype wire

// [fan_pwm_override_spinup_tb_top.sv]
// self-checking bench for the first fan output control block
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_override_spinup_tb_top;
    import fan_pwm_pkg::*;
    localparam int TICK = 4;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic cfg_lock = 1'b0;
    logic [3:0] auto_duty_code = 4'h0;
    logic cpu_hot_event = 1'b0;
    logic fan_output_one;
    logic kick_active;
    logic [3:0] high_count;
    logic [7:0] rd;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    always #12.5 mclk = ~mclk;

    fan_pwm_override_spinup #(.MS_TICK(TICK)) u_fan_pwm_override_spinup (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cfg_lock(cfg_lock), .auto_duty_code(auto_duty_code),
        .cpu_hot_event(cpu_hot_event), .fan_output_one(fan_output_one),
        .kick_active(kick_active));

    fan_drive_model u_fan_drive_model (
        .mclk(mclk), .pwm_in(fan_output_one), .high_count(high_count));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        rd = reg_rdata;
        check(rd, exp);
    endtask

    // a full frame plus the kick timer's load cycle must pass first
    task automatic duty(input logic [3:0] exp);
        repeat (17) @(negedge mclk);
        check({4'h0, high_count}, {4'h0, exp});
    endtask

    task automatic hot_pulse;
        cpu_hot_event = 1'b1;
        repeat (2) @(negedge mclk);
        cpu_hot_event = 1'b0;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        rdchk(ADDR_OVERRIDE_LOCK, OVERRIDE_LOCK_RESET);
        rdchk(ADDR_SPINUP_SETUP, SPINUP_SETUP_RESET);
        rdchk(8'hcb, UNMAPPED_READ);
        // manual code 3 while kick duty is 0
        reg_write(ADDR_OVERRIDE_LOCK, 8'h31);
        duty(4'h3);
        check({7'h00, kick_active}, 8'h00);
        rdchk(ADDR_OVERRIDE_LOCK, 8'h31);
        auto_duty_code = 4'h5;
        duty(4'h5);
        rdchk(ADDR_OVERRIDE_LOCK, 8'h51);
        reg_write(ADDR_OVERRIDE_LOCK, 8'hf1);
        duty(4'hf);
        reg_write(ADDR_OVERRIDE_LOCK, 8'hf3);
        duty(4'h0);
        // hot lock: ignored while disabled, then held and cleared under lock
        reg_write(ADDR_OVERRIDE_LOCK, 8'h00);
        auto_duty_code = 4'h2;
        hot_pulse();
        rdchk(ADDR_OVERRIDE_LOCK, 8'h20);
        reg_write(ADDR_OVERRIDE_LOCK, 8'h04);
        hot_pulse();
        duty(4'hf);
        rdchk(ADDR_OVERRIDE_LOCK, 8'hfc);
        cfg_lock = 1'b1;
        reg_write(ADDR_OVERRIDE_LOCK, 8'h01);
        duty(4'h2);
        rdchk(ADDR_OVERRIDE_LOCK, 8'h24);
        cfg_lock = 1'b0;
        // kick of duty 10 for 100 ms, then code 8 for 6 s
        reg_write(ADDR_OVERRIDE_LOCK, 8'h00);
        auto_duty_code = 4'h0;
        reg_write(ADDR_SPINUP_SETUP, 8'h2a);
        duty(4'h0);
        auto_duty_code = 4'h2;
        duty(4'ha);
        rdchk(ADDR_OVERRIDE_LOCK, 8'h00);
        repeat (361) @(negedge mclk);
        check({7'h00, kick_active}, 8'h01);
        repeat (40) @(negedge mclk);
        check({7'h00, kick_active}, 8'h00);
        duty(4'h2);
        rdchk(ADDR_OVERRIDE_LOCK, 8'h20);
        auto_duty_code = 4'h0;
        reg_write(ADDR_SPINUP_SETUP, 8'h1a);
        rdchk(ADDR_SPINUP_SETUP, 8'h1a);
        duty(4'h0);
        auto_duty_code = 4'h3;
        repeat (23950) @(negedge mclk);
        check({7'h00, kick_active}, 8'h01);
        repeat (100) @(negedge mclk);
        check({7'h00, kick_active}, 8'h00);
        duty(4'h3);
        give_verdict();
    end
endmodule // fan_pwm_override_spinup_tb_top
`default_nettype wire
